/* logic/dtopt_pkg.sv */
// Constants, register map and types of the detection option control block.
package dtopt_pkg;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned SAMPLE_MAX_NS = 4720;
   // A longest time rounds down to whole cycles.
   localparam int unsigned FILT_CYC = SAMPLE_MAX_NS / CLK_PERIOD_NS;
   // Raw sampling is shorter; the filter needs the longer carrier-on time.
   localparam int unsigned RAW_CYC = FILT_CYC / 4;
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILT_CYC - 1);
   localparam logic [CNT_W-1:0] RAW_LAST = CNT_W'(RAW_CYC - 1);

   // ----------------------------------------
   // Measurement and transmitter
   // ----------------------------------------
   localparam int MEAS_W = 6;
   localparam int ACC_W = 8;
   localparam int FRAC_W = 2;
   localparam int DROP_W = 9;
   localparam logic [DROP_W-1:0] TX_DROP_MV = 9'h190;
   localparam logic [DROP_W-1:0] TX_DROP_NONE = 9'h000;

   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_OPTIONS = 8'h3A;
   localparam logic [7:0] IDX_QLOWER = 8'h3F;
   localparam logic [7:0] IDX_QUPPER = 8'h40;
   localparam logic [7:0] IDX_ILOWER = 8'h41;
   localparam logic [7:0] IDX_RES_I = 8'h42;
   localparam logic [7:0] IDX_RES_Q = 8'h43;
   localparam logic [7:0] IDX_STATUS = 8'h50;
   localparam logic [7:0] IDX_MASK = 8'h51;
   localparam logic [7:0] IDX_CTRL = 8'h52;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int OPT_TXF = 3;
   localparam int OPT_FLT = 2;
   localparam int OPT_QDR = 1;
   localparam int OPT_IDR = 0;
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam logic [7:0] BORDER_RESET = 8'h00;
   localparam int RES_IRQCLR = 6;
   localparam int CTRL_START = 0;
   localparam int ST_DET = 0;
   localparam int ST_DONE = 1;
   localparam int ST_W = 2;
   localparam logic [ST_W-1:0] ST_RESET = 2'h0;

   typedef enum logic [2:0] {
      DTOPT_IDLE = 3'b001,
      DTOPT_SAMP = 3'b010,
      DTOPT_EVAL = 3'b100
   } dtopt_state_e;

endpackage

/* logic/dtopt_chan_filter.sv */
// Per-channel sample filter with drift detection over one measurement.
module dtopt_chan_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic sample_valid,
   input wire logic [dtopt_pkg::MEAS_W-1:0] sample,
   output logic [dtopt_pkg::MEAS_W-1:0] filtered,
   output logic [dtopt_pkg::MEAS_W-1:0] raw_last,
   output logic drift
);
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [dtopt_pkg::ACC_W-1:0] acc;
      logic [dtopt_pkg::MEAS_W-1:0] first;
      logic [dtopt_pkg::MEAS_W-1:0] last;
      logic have_first;
      logic drift;
   } dtopt_filt_s;

   dtopt_filt_s q;
   dtopt_filt_s d;

   // ----------------------------------------
   // Filter
   // ----------------------------------------
   // A first-order low pass holds four times the mean; the two extra
   // bits keep rounding from biasing the result low.
   always_comb begin
      d = q;
      if (clear) begin
         d.have_first = 1'b0;
         d.drift = 1'b0;
      end else if (sample_valid) begin
         d.last = sample;
         if (!q.have_first) begin
            d.have_first = 1'b1;
            d.first = sample;
            d.acc = {sample, 2'b00};
         end else begin
            d.drift = q.drift | (sample != q.first);
            d.acc = q.acc - (q.acc >> dtopt_pkg::FRAC_W)
                    + {2'b00, sample};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign filtered = q.acc[dtopt_pkg::ACC_W-1:dtopt_pkg::FRAC_W];
   assign raw_last = q.last;
   assign drift = q.drift;

endmodule

/* logic/dtopt_window_cmp.sv */
// Window comparator over the in-phase and quadrature measurements.
module dtopt_window_cmp (
   input wire logic [dtopt_pkg::MEAS_W-1:0] meas_i,
   input wire logic [dtopt_pkg::MEAS_W-1:0] meas_q,
   input wire logic [dtopt_pkg::MEAS_W-1:0] inphase_lower_border,
   input wire logic [dtopt_pkg::MEAS_W-1:0] inphase_upper_border,
   input wire logic [dtopt_pkg::MEAS_W-1:0] quad_lower_border,
   input wire logic [dtopt_pkg::MEAS_W-1:0] quad_upper_border,
   output logic outside
);
   timeunit 1ns;
   timeprecision 100ps;

   // A card detunes the antenna, so either border counts as a hit.
   assign outside = (meas_i < inphase_lower_border)
                  | (meas_i > inphase_upper_border)
                  | (meas_q < quad_lower_border)
                  | (meas_q > quad_upper_border);

endmodule

/* logic/dtopt_top.sv */
// Detection option control: APB registers, measurement sequencer, IRQ.
module dtopt_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dtopt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic detect_start,
   input wire logic adc_valid,
   input wire logic [dtopt_pkg::MEAS_W-1:0] adc_i,
   input wire logic [dtopt_pkg::MEAS_W-1:0] adc_q,
   output logic carrier_on,
   output logic tx_full_swing,
   output logic [dtopt_pkg::DROP_W-1:0] tx_drop_mv,
   output logic busy,
   output logic irq
);
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      dtopt_pkg::dtopt_state_e st;
      logic [dtopt_pkg::CNT_W-1:0] cnt;
      logic run_filt;
      logic [7:0] opt;
      logic [7:0] qlower;
      logic [7:0] qupper;
      logic [7:0] ilower;
      logic irq_clr;
      logic [dtopt_pkg::MEAS_W-1:0] res_i;
      logic [dtopt_pkg::MEAS_W-1:0] res_q;
      logic [dtopt_pkg::ST_W-1:0] status;
      logic [dtopt_pkg::ST_W-1:0] mask;
      logic [31:0] prdata;
   } dtopt_regs_s;

   dtopt_regs_s q;
   dtopt_regs_s d;

   logic [7:0] idx;
   logic aligned;
   logic mapped;
   logic wr;
   logic rd_setup;
   logic start_req;
   logic in_samp;
   logic in_eval;
   logic [dtopt_pkg::CNT_W-1:0] last_cnt;
   logic [1:0] ch_valid;
   logic [1:0][dtopt_pkg::MEAS_W-1:0] ch_sample;
   logic [1:0][dtopt_pkg::MEAS_W-1:0] ch_filt;
   logic [1:0][dtopt_pkg::MEAS_W-1:0] ch_raw;
   logic [1:0] ch_drift;
   logic [dtopt_pkg::MEAS_W-1:0] meas_i;
   logic [dtopt_pkg::MEAS_W-1:0] meas_q;
   logic [dtopt_pkg::MEAS_W-1:0] iupper;
   logic outside;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign idx = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
   assign mapped = aligned && (idx == dtopt_pkg::IDX_OPTIONS
      || idx == dtopt_pkg::IDX_QLOWER || idx == dtopt_pkg::IDX_QUPPER
      || idx == dtopt_pkg::IDX_ILOWER || idx == dtopt_pkg::IDX_RES_I
      || idx == dtopt_pkg::IDX_RES_Q || idx == dtopt_pkg::IDX_STATUS
      || idx == dtopt_pkg::IDX_MASK || idx == dtopt_pkg::IDX_CTRL);
   assign wr = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   // Read data is registered in the setup phase, so no wait state is needed.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign in_samp = (q.st == dtopt_pkg::DTOPT_SAMP);
   assign in_eval = (q.st == dtopt_pkg::DTOPT_EVAL);
   assign start_req = detect_start || (wr && idx == dtopt_pkg::IDX_CTRL
                      && pwdata[dtopt_pkg::CTRL_START]);
   // The filter needs the longer carrier-on time; both stay within limit.
   assign last_cnt = q.run_filt ? dtopt_pkg::FILT_LAST
                                : dtopt_pkg::RAW_LAST;

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   assign ch_sample[0] = adc_i;
   assign ch_sample[1] = adc_q;

   for (genvar c = 0; c < 2; c++) begin : g_chan
      assign ch_valid[c] = adc_valid && in_samp;
      dtopt_chan_filter u_filt (
         .pclk(pclk),
         .presetn(presetn),
         .clear(start_req && q.st == dtopt_pkg::DTOPT_IDLE),
         .sample_valid(ch_valid[c]),
         .sample(ch_sample[c]),
         .filtered(ch_filt[c]),
         .raw_last(ch_raw[c]),
         .drift(ch_drift[c])
      );
   end

   assign meas_i = q.run_filt ? ch_filt[0] : ch_raw[0];
   assign meas_q = q.run_filt ? ch_filt[1] : ch_raw[1];
   // The upper in-phase border is scattered over three registers.
   assign iupper = {q.qlower[7:6], q.qupper[7:6], q.ilower[7:6]};

   dtopt_window_cmp u_win (
      .meas_i(meas_i),
      .meas_q(meas_q),
      .inphase_lower_border(q.ilower[5:0]),
      .inphase_upper_border(iupper),
      .quad_lower_border(q.qlower[5:0]),
      .quad_upper_border(q.qupper[5:0]),
      .outside(outside)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      unique case (q.st)
         dtopt_pkg::DTOPT_IDLE: begin
            if (start_req) begin
               d.st = dtopt_pkg::DTOPT_SAMP;
               d.cnt = '0;
               d.irq_clr = 1'b0;
               d.run_filt = q.opt[dtopt_pkg::OPT_FLT];
            end
         end
         dtopt_pkg::DTOPT_SAMP: begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == last_cnt) begin
               d.st = dtopt_pkg::DTOPT_EVAL;
            end
         end
         dtopt_pkg::DTOPT_EVAL: begin
            d.st = dtopt_pkg::DTOPT_IDLE;
         end
      endcase

      if (wr) begin
         unique case (idx)
            dtopt_pkg::IDX_OPTIONS: begin
               d.opt[dtopt_pkg::OPT_TXF] = pwdata[dtopt_pkg::OPT_TXF];
               d.opt[dtopt_pkg::OPT_FLT] = pwdata[dtopt_pkg::OPT_FLT];
            end
            dtopt_pkg::IDX_QLOWER: d.qlower = pwdata[7:0];
            dtopt_pkg::IDX_QUPPER: d.qupper = pwdata[7:0];
            dtopt_pkg::IDX_ILOWER: d.ilower = pwdata[7:0];
            dtopt_pkg::IDX_RES_Q: begin
               d.irq_clr = pwdata[dtopt_pkg::RES_IRQCLR];
            end
            dtopt_pkg::IDX_STATUS: begin
               d.status = q.status & ~pwdata[dtopt_pkg::ST_W-1:0];
            end
            dtopt_pkg::IDX_MASK: d.mask = pwdata[dtopt_pkg::ST_W-1:0];
            default: begin
            end
         endcase
      end

      // Sets come after the software clear, so an event never gets lost.
      if (in_eval) begin
         d.res_i = meas_i;
         d.res_q = meas_q;
         d.opt[dtopt_pkg::OPT_QDR] = ch_drift[1];
         d.opt[dtopt_pkg::OPT_IDR] = ch_drift[0];
         d.status[dtopt_pkg::ST_DONE] = 1'b1;
         if (outside && !d.irq_clr) begin
            d.status[dtopt_pkg::ST_DET] = 1'b1;
         end
      end

      if (rd_setup) begin
         d.prdata = '0;
         if (aligned) begin
            unique case (idx)
               dtopt_pkg::IDX_OPTIONS: d.prdata[7:0] = {4'h0, q.opt[3:0]};
               dtopt_pkg::IDX_QLOWER: d.prdata[7:0] = q.qlower;
               dtopt_pkg::IDX_QUPPER: d.prdata[7:0] = q.qupper;
               dtopt_pkg::IDX_ILOWER: d.prdata[7:0] = q.ilower;
               dtopt_pkg::IDX_RES_I: d.prdata[7:0] = {2'b00, q.res_i};
               dtopt_pkg::IDX_RES_Q: begin
                  d.prdata[7:0] = {1'b0, q.irq_clr, q.res_q};
               end
               dtopt_pkg::IDX_STATUS: begin
                  d.prdata[dtopt_pkg::ST_W-1:0] = q.status;
               end
               dtopt_pkg::IDX_MASK: d.prdata[dtopt_pkg::ST_W-1:0] = q.mask;
               dtopt_pkg::IDX_CTRL: d.prdata[0] = busy;
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.st <= dtopt_pkg::DTOPT_IDLE;
         q.cnt <= '0;
         q.run_filt <= 1'b0;
         q.opt <= dtopt_pkg::OPT_RESET;
         q.qlower <= dtopt_pkg::BORDER_RESET;
         q.qupper <= dtopt_pkg::BORDER_RESET;
         q.ilower <= dtopt_pkg::BORDER_RESET;
         q.irq_clr <= 1'b0;
         q.res_i <= '0;
         q.res_q <= '0;
         q.status <= dtopt_pkg::ST_RESET;
         q.mask <= dtopt_pkg::ST_RESET;
         q.prdata <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = q.prdata;
   assign busy = !(q.st == dtopt_pkg::DTOPT_IDLE);
   assign carrier_on = in_samp;
   // Full swing buys detection range at the price of supply current.
   assign tx_full_swing = in_samp && q.opt[dtopt_pkg::OPT_TXF];
   assign tx_drop_mv = (in_samp && !q.opt[dtopt_pkg::OPT_TXF])
                       ? dtopt_pkg::TX_DROP_MV
                       : dtopt_pkg::TX_DROP_NONE;
   assign irq = |(q.status & q.mask);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [dtopt_pkg::CNT_W:0] on_len;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_len <= '0;
      end else begin
         on_len <= carrier_on ? on_len + 1'b1 : '0;
      end
   end

   property p_full_swing;
      @(posedge pclk) disable iff (!presetn)
      (carrier_on && q.opt[dtopt_pkg::OPT_TXF])
         |-> tx_full_swing && tx_drop_mv == dtopt_pkg::TX_DROP_NONE;
   endproperty
   a_full_swing: assert property (p_full_swing)
      else $error("Full swing not driven during measurement.");

   property p_reduced_swing;
      @(posedge pclk) disable iff (!presetn)
      (carrier_on && !q.opt[dtopt_pkg::OPT_TXF])
         |-> !tx_full_swing && tx_drop_mv == dtopt_pkg::TX_DROP_MV;
   endproperty
   a_reduced_swing: assert property (p_reduced_swing)
      else $error("Reduced transmitter level not applied.");

   property p_filter_long;
      @(posedge pclk) disable iff (!presetn)
      ($fell(carrier_on) && q.run_filt)
         |-> $past(on_len) == (dtopt_pkg::CNT_W+1)'(dtopt_pkg::FILT_CYC - 1);
   endproperty
   a_filter_long: assert property (p_filter_long)
      else $error("Filtered measurement has the wrong length.");

   property p_sample_max;
      @(posedge pclk) disable iff (!presetn)
      carrier_on |-> on_len < dtopt_pkg::FILT_CYC;
   endproperty
   a_sample_max: assert property (p_sample_max)
      else $error("Sampling interval exceeds its maximum.");

   property p_quad_drift;
      @(posedge pclk) disable iff (!presetn)
      in_eval |=> q.opt[dtopt_pkg::OPT_QDR] == $past(ch_drift[1]);
   endproperty
   a_quad_drift: assert property (p_quad_drift)
      else $error("Quadrature drift flag wrong after measurement.");

   property p_inphase_drift;
      @(posedge pclk) disable iff (!presetn)
      in_eval |=> q.opt[dtopt_pkg::OPT_IDR] == $past(ch_drift[0]);
   endproperty
   a_inphase_drift: assert property (p_inphase_drift)
      else $error("In-phase drift flag wrong after measurement.");

   property p_detect_irq;
      @(posedge pclk) disable iff (!presetn)
      (in_eval && outside && !q.irq_clr
         && !(wr && idx == dtopt_pkg::IDX_RES_Q))
         |=> q.status[dtopt_pkg::ST_DET]
             && (irq || !q.mask[dtopt_pkg::ST_DET]);
   endproperty
   a_detect_irq: assert property (p_detect_irq)
      else $error("Out-of-window measurement raised no detection.");

   property p_flags_hold;
      @(posedge pclk) disable iff (!presetn)
      !in_eval |=> $stable(q.opt[dtopt_pkg::OPT_QDR:dtopt_pkg::OPT_IDR]);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("Drift flags changed outside measurement end.");

endmodule

/* bench/detection_option_control_test.sv */
// Self-checking testbench of the detection option control block.
`define CHECK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end

module detection_option_control_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [dtopt_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic detect_start;
   logic adc_valid;
   logic [dtopt_pkg::MEAS_W-1:0] adc_i;
   logic [dtopt_pkg::MEAS_W-1:0] adc_q;
   logic carrier_on;
   logic tx_full_swing;
   logic [dtopt_pkg::DROP_W-1:0] tx_drop_mv;
   logic busy;
   logic irq;
   int fail_count;
   int checked;
   logic [31:0] v;
   logic e;

   dtopt_top uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .detect_start(detect_start),
      .adc_valid(adc_valid),
      .adc_i(adc_i),
      .adc_q(adc_q),
      .carrier_on(carrier_on),
      .tx_full_swing(tx_full_swing),
      .tx_drop_mv(tx_drop_mv),
      .busy(busy),
      .irq(irq)
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ----------------------------------------
   // Bus and closing tasks
   // ----------------------------------------
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [1:0] off, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, off};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         fail_count++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic x;
      apb(1'b1, idx, 2'b00, d, r, x);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] r);
      logic x;
      apb(1'b0, idx, 2'b00, 32'h0000_0000, r, x);
   endtask

   // Mode 1 wobbles the I sample, mode 2 the Q sample, mode 0 holds both.
   task automatic measure(input logic [1:0] mode, input logic [5:0] i,
                          input logic [5:0] q, input logic full,
                          input int cyc);
      int k;
      int cnt;
      cnt = 0;
      @(posedge pclk);
      detect_start <= 1'b1;
      adc_valid <= 1'b1;
      adc_i <= i;
      adc_q <= q;
      @(posedge pclk);
      detect_start <= 1'b0;
      for (k = 0; k < 3000; k++) begin
         @(posedge pclk);
         if (carrier_on === 1'b1) cnt++;
         if (cnt == 1 && carrier_on === 1'b1) begin
            `CHECK(tx_full_swing, full)
            `CHECK(busy, 1'b1)
            `CHECK(tx_drop_mv, full ? 9'h000 : dtopt_pkg::TX_DROP_MV)
         end
         adc_i <= (mode == 2'd1) ? {i[5:1], i[0] ^ k[0]} : i;
         adc_q <= (mode == 2'd2) ? {q[5:1], q[0] ^ k[0]} : q;
         if (cnt > 0 && busy !== 1'b1) break;
      end
      adc_valid <= 1'b0;
      if (k == 3000) begin
         fail_count++;
         results();
      end
      `CHECK(cnt, cyc)
      `CHECK(cnt * 4 <= 4720, 1'b1)
      `CHECK(tx_drop_mv, dtopt_pkg::TX_DROP_NONE)
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(dtopt_pkg::IDX_OPTIONS, v);
      `CHECK(v, 32'h0000_0000)
      rd(dtopt_pkg::IDX_MASK, v);
      `CHECK(v, 32'h0000_0000)
      `CHECK(pready, 1'b1)
      apb(1'b0, dtopt_pkg::IDX_OPTIONS, 2'b01, 32'h0000_0000, v, e);
      `CHECK({e, v}, 33'h0_0000_0000 | 33'h1_0000_0000)
      // The drift flags are read-only, so writing ones must not stick.
      wr(dtopt_pkg::IDX_OPTIONS, 32'h0000_00FF);
      rd(dtopt_pkg::IDX_OPTIONS, v);
      `CHECK(v, 32'h0000_000C)
   endtask

   task automatic t_tx();
      wr(dtopt_pkg::IDX_OPTIONS, 32'h0000_0008);
      measure(2'd0, 6'd20, 6'd20, 1'b1, int'(dtopt_pkg::RAW_CYC));
      wr(dtopt_pkg::IDX_OPTIONS, 32'h0000_0000);
      measure(2'd0, 6'd20, 6'd20, 1'b0, int'(dtopt_pkg::RAW_CYC));
   endtask

   task automatic t_filter();
      wr(dtopt_pkg::IDX_OPTIONS, 32'h0000_0004);
      measure(2'd0, 6'd20, 6'd20, 1'b0, int'(dtopt_pkg::FILT_CYC));
      rd(dtopt_pkg::IDX_OPTIONS, v);
      `CHECK(v, 32'h0000_0004)
      measure(2'd1, 6'd20, 6'd20, 1'b0, int'(dtopt_pkg::FILT_CYC));
      rd(dtopt_pkg::IDX_OPTIONS, v);
      `CHECK(v, 32'h0000_0005)
      repeat (40) @(posedge pclk);
      rd(dtopt_pkg::IDX_OPTIONS, v);
      `CHECK(v, 32'h0000_0005)
      measure(2'd2, 6'd20, 6'd20, 1'b0, int'(dtopt_pkg::FILT_CYC));
      rd(dtopt_pkg::IDX_OPTIONS, v);
      `CHECK(v, 32'h0000_0006)
   endtask

   // I lower border 10, every other border wide open.
   task automatic t_window();
      wr(dtopt_pkg::IDX_OPTIONS, 32'h0000_0000);
      wr(dtopt_pkg::IDX_QLOWER, 32'h0000_00C0);
      wr(dtopt_pkg::IDX_QUPPER, 32'h0000_00FF);
      wr(dtopt_pkg::IDX_ILOWER, 32'h0000_00CA);
      wr(dtopt_pkg::IDX_STATUS, 32'h0000_0003);
      measure(2'd0, 6'd10, 6'd20, 1'b0, int'(dtopt_pkg::RAW_CYC));
      rd(dtopt_pkg::IDX_STATUS, v);
      `CHECK(v, 32'h0000_0002)
      rd(dtopt_pkg::IDX_RES_I, v);
      `CHECK(v, 32'h0000_000A)
      measure(2'd0, 6'd9, 6'd20, 1'b0, int'(dtopt_pkg::RAW_CYC));
      rd(dtopt_pkg::IDX_STATUS, v);
      `CHECK(v, 32'h0000_0003)
      `CHECK(irq, 1'b0)
      wr(dtopt_pkg::IDX_MASK, 32'h0000_0001);
      @(posedge pclk);
      `CHECK(irq, 1'b1)
      wr(dtopt_pkg::IDX_STATUS, 32'h0000_0001);
      @(posedge pclk);
      `CHECK(irq, 1'b0)
      rd(dtopt_pkg::IDX_STATUS, v);
      `CHECK(v, 32'h0000_0002)
   endtask

   // Start by register, then mute the detection for the rest of that run.
   task automatic t_ctrl();
      int n;
      wr(dtopt_pkg::IDX_STATUS, 32'h0000_0003);
      wr(dtopt_pkg::IDX_CTRL, 32'h0000_0001);
      wr(dtopt_pkg::IDX_RES_Q, 32'h0000_0040);
      rd(dtopt_pkg::IDX_CTRL, v);
      `CHECK(v, 32'h0000_0001)
      rd(dtopt_pkg::IDX_RES_Q, v);
      `CHECK(v, 32'h0000_0054)
      for (n = 0; n < 400 && busy !== 1'b0; n++) begin
         @(posedge pclk);
      end
      if (n == 400) begin
         fail_count++;
         results();
      end
      rd(dtopt_pkg::IDX_STATUS, v);
      `CHECK(v, 32'h0000_0002)
      `CHECK(irq, 1'b0)
      measure(2'd0, 6'd9, 6'd20, 1'b0, int'(dtopt_pkg::RAW_CYC));
      rd(dtopt_pkg::IDX_RES_Q, v);
      `CHECK(v, 32'h0000_0014)
      `CHECK(irq, 1'b1)
      // Q below its lower border of 21, I inside its window.
      wr(dtopt_pkg::IDX_QLOWER, 32'h0000_00D5);
      wr(dtopt_pkg::IDX_STATUS, 32'h0000_0003);
      measure(2'd0, 6'd10, 6'd20, 1'b0, int'(dtopt_pkg::RAW_CYC));
      rd(dtopt_pkg::IDX_STATUS, v);
      `CHECK(v, 32'h0000_0003)
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      fail_count = 0;
      checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      detect_start = 1'b0;
      adc_valid = 1'b0;
      adc_i = '0;
      adc_q = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_tx();
      t_filter();
      t_window();
      t_ctrl();
      results();
   end
endmodule
